// ==== design/dpll_mode_control_regs.sv ====
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - policy 0 manual, 2 automatic choice
// - manual bit picks input a or b
// - revert bit enables revertive switching
// - seamless bit enables hitless switching
// - swap bit uses locking filter in acquire
// - lost reference goes holdover or freerun
// - frequency word write suppresses filter update
// - enable clear means synthesizer, gated loop
// - select 0 freerun, 2 holdover
// - select 1 normal, 3 write frequency
// - switch shift used only when hitless
// - main shift zero means feed through
// - crystal trim is signed two's complement
module dpll_mode_control_regs (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	input  wire logic        ref_a_valid,
	input  wire logic        ref_b_valid,
	input  wire logic        lock_achieved,
	input  wire logic        freq_word_wr,
	output logic             ref_input_b_sel,
	output logic             revertive_en,
	output logic             hitless_en,
	output logic             use_lock_filter,
	output logic             filter_update_en,
	output logic             loop_clk_en,
	output logic      [3:0]  main_decim_shift,
	output logic             main_decim_bypass,
	output logic      [2:0]  switch_decim_shift,
	output logic signed [7:0] crystal_offset_ppm,
	output logic      [2:0]  loop_state
);
	// ------------------------------------------------------------
	// pin synchronisers (three stages, second and third must agree)
	// ------------------------------------------------------------
	logic [2:0] sync_a_r, sync_b_r, sync_l_r, sync_f_r;
	logic       a_ok_r, b_ok_r, lock_r, fw_lvl_r, fw_prev_r;
	logic       a_ok_nxt, b_ok_nxt, lock_nxt, fw_lvl_nxt;

	always_comb begin
		a_ok_nxt   = (sync_a_r[1] == sync_a_r[2]) ? sync_a_r[2] : a_ok_r;
		b_ok_nxt   = (sync_b_r[1] == sync_b_r[2]) ? sync_b_r[2] : b_ok_r;
		lock_nxt   = (sync_l_r[1] == sync_l_r[2]) ? sync_l_r[2] : lock_r;
		fw_lvl_nxt = (sync_f_r[1] == sync_f_r[2]) ? sync_f_r[2] : fw_lvl_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a_r  <= 3'h0;
			sync_b_r  <= 3'h0;
			sync_l_r  <= 3'h0;
			sync_f_r  <= 3'h0;
			a_ok_r    <= 1'b0;
			b_ok_r    <= 1'b0;
			lock_r    <= 1'b0;
			fw_lvl_r  <= 1'b0;
			fw_prev_r <= 1'b0;
		end else begin
			sync_a_r  <= {sync_a_r[1:0], ref_a_valid};
			sync_b_r  <= {sync_b_r[1:0], ref_b_valid};
			sync_l_r  <= {sync_l_r[1:0], lock_achieved};
			sync_f_r  <= {sync_f_r[1:0], freq_word_wr};
			a_ok_r    <= a_ok_nxt;
			b_ok_r    <= b_ok_nxt;
			lock_r    <= lock_nxt;
			fw_lvl_r  <= fw_lvl_nxt;
			fw_prev_r <= fw_lvl_r;
		end
	end

	wire logic fw_pulse = fw_lvl_r & ~fw_prev_r;

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	logic [7:0] ref_src_r, mode_r, decim_r, xtal_r;
	logic [7:0] ref_src_nxt, mode_nxt, decim_nxt, xtal_nxt;
	logic       ack_r, ack_nxt, err_r, err_nxt;
	logic [31:0] rdat_r, rdat_nxt;

	function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] wd,
		input logic [7:0] mask, input logic lane);
		merge = lane ? ((old_v & ~mask) | (wd & mask)) : old_v;
	endfunction : merge

	dpll_ctrl_pkg::loop_state_e st_r, st_nxt;

	wire logic req     = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
	wire logic hit     = (wb_adr_i == dpll_ctrl_pkg::ADDR_REF_SOURCE)
		| (wb_adr_i == dpll_ctrl_pkg::ADDR_LOOP_MODE)
		| (wb_adr_i == dpll_ctrl_pkg::ADDR_DECIMATION)
		| (wb_adr_i == dpll_ctrl_pkg::ADDR_CRYSTAL);
	wire logic wr      = req & hit & wb_we_i;

	always_comb begin
		ref_src_nxt = ref_src_r;
		mode_nxt    = mode_r;
		decim_nxt   = decim_r;
		xtal_nxt    = xtal_r;
		ack_nxt     = req & hit;
		err_nxt     = req & ~hit;
		rdat_nxt    = 32'h0;
		if (wr) begin
			case (wb_adr_i)
				dpll_ctrl_pkg::ADDR_REF_SOURCE: ref_src_nxt = merge(ref_src_r, wb_dat_i[7:0],
					dpll_ctrl_pkg::REF_SOURCE_MASK, wb_sel_i[0]);
				dpll_ctrl_pkg::ADDR_LOOP_MODE: mode_nxt = merge(mode_r, wb_dat_i[7:0],
					dpll_ctrl_pkg::LOOP_MODE_MASK, wb_sel_i[0]);
				dpll_ctrl_pkg::ADDR_DECIMATION: decim_nxt = merge(decim_r, wb_dat_i[7:0],
					dpll_ctrl_pkg::DECIMATION_MASK, wb_sel_i[0]);
				dpll_ctrl_pkg::ADDR_CRYSTAL: xtal_nxt = merge(xtal_r, wb_dat_i[7:0],
					dpll_ctrl_pkg::CRYSTAL_MASK, wb_sel_i[0]);
				default: ;
			endcase
		end
		if (req & hit & ~wb_we_i) begin
			case (wb_adr_i)
				dpll_ctrl_pkg::ADDR_REF_SOURCE: rdat_nxt = {24'h0, ref_src_r};
				// loop state shown in bits 10:8 of the mode word
				dpll_ctrl_pkg::ADDR_LOOP_MODE:  rdat_nxt = {21'h0, st_r, mode_r};
				dpll_ctrl_pkg::ADDR_DECIMATION: rdat_nxt = {24'h0, decim_r};
				dpll_ctrl_pkg::ADDR_CRYSTAL:    rdat_nxt = {24'h0, xtal_r};
				default:                        rdat_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_src_r <= dpll_ctrl_pkg::REF_SOURCE_RESET;
			mode_r    <= dpll_ctrl_pkg::LOOP_MODE_RESET;
			decim_r   <= dpll_ctrl_pkg::DECIMATION_RESET;
			xtal_r    <= dpll_ctrl_pkg::CRYSTAL_RESET;
			ack_r     <= 1'b0;
			err_r     <= 1'b0;
			rdat_r    <= 32'h0;
		end else begin
			ref_src_r <= ref_src_nxt;
			mode_r    <= mode_nxt;
			decim_r   <= decim_nxt;
			xtal_r    <= xtal_nxt;
			ack_r     <= ack_nxt;
			err_r     <= err_nxt;
			rdat_r    <= rdat_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_err_o = err_r;
	assign wb_dat_o = rdat_r;

	// ------------------------------------------------------------
	// decoded fields
	// ------------------------------------------------------------
	wire logic [1:0] policy  = ref_src_r[dpll_ctrl_pkg::POLICY_LSB +: 2];
	wire logic       manual  = ref_src_r[dpll_ctrl_pkg::MANUAL_BIT];
	wire logic       swap    = mode_r[dpll_ctrl_pkg::SWAP_BIT];
	wire logic       lost_fr = mode_r[dpll_ctrl_pkg::LOST_BIT];
	wire logic       freeze  = mode_r[dpll_ctrl_pkg::FREEZE_BIT];
	wire logic       enable  = mode_r[dpll_ctrl_pkg::ENABLE_BIT];
	wire logic [1:0] sel     = mode_r[dpll_ctrl_pkg::STATE_LSB +: 2];

	// ------------------------------------------------------------
	// reference choice
	// ------------------------------------------------------------
	logic ref_b_r, ref_b_nxt;
	wire logic cur_ok = ref_b_r ? b_ok_r : a_ok_r;
	wire logic revertive_en_w = ref_src_r[dpll_ctrl_pkg::REVERT_BIT];
	wire logic hitless_en_w   = ref_src_r[dpll_ctrl_pkg::SEAMLESS_BIT];

	always_comb begin
		ref_b_nxt = ref_b_r;
		if (policy == dpll_ctrl_pkg::POLICY_MANUAL) begin
			ref_b_nxt = manual;
		end else if (policy == dpll_ctrl_pkg::POLICY_AUTO) begin
			// a is the preferred input; revertive returns to it once it is good again
			if (!cur_ok && (ref_b_r ? a_ok_r : b_ok_r))
				ref_b_nxt = ~ref_b_r;
			else if (ref_b_r && a_ok_r && revertive_en_w)
				ref_b_nxt = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// loop state machine
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		if (!enable) begin
			st_nxt = dpll_ctrl_pkg::ST_SYNTH;
		end else begin
			case (sel)
				dpll_ctrl_pkg::SEL_FREERUN:   st_nxt = dpll_ctrl_pkg::ST_FREERUN;
				dpll_ctrl_pkg::SEL_HOLDOVER:  st_nxt = dpll_ctrl_pkg::ST_HOLDOVER;
				dpll_ctrl_pkg::SEL_WRITEFREQ: st_nxt = dpll_ctrl_pkg::ST_WRITEFREQ;
				default: begin
					// automatic normal mode
					if (!cur_ok)
						st_nxt = lost_fr ? dpll_ctrl_pkg::ST_FREERUN
							: dpll_ctrl_pkg::ST_HOLDOVER;
					else if (st_r == dpll_ctrl_pkg::ST_LOCKED)
						st_nxt = dpll_ctrl_pkg::ST_LOCKED;
					else
						st_nxt = lock_r ? dpll_ctrl_pkg::ST_LOCKED
							: dpll_ctrl_pkg::ST_ACQUIRE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r    <= dpll_ctrl_pkg::ST_SYNTH;
			ref_b_r <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			ref_b_r <= ref_b_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs to the loop datapath
	// ------------------------------------------------------------
	assign ref_input_b_sel    = ref_b_r;
	assign revertive_en       = revertive_en_w;
	assign hitless_en         = hitless_en_w;
	assign use_lock_filter    = swap & (st_r == dpll_ctrl_pkg::ST_ACQUIRE);
	// freeze is software's duty during reconfig; a frequency word write pauses updates itself
	assign filter_update_en   = ~freeze & ~fw_pulse;
	assign loop_clk_en        = enable;
	assign main_decim_shift   = decim_r[dpll_ctrl_pkg::MN_SHIFT_LSB +: 4];
	assign main_decim_bypass  = (decim_r[dpll_ctrl_pkg::MN_SHIFT_LSB +: 4] == 4'h0);
	assign switch_decim_shift = hitless_en_w
		? decim_r[dpll_ctrl_pkg::SW_SHIFT_LSB +: 3] : 3'h0;
	assign crystal_offset_ppm = $signed(xtal_r);
	assign loop_state         = st_r;
endmodule : dpll_mode_control_regs

`default_nettype wire

// ==== include/dpll_ctrl_pkg.sv ====
package dpll_ctrl_pkg;
	// ------------------------------------------------------------
	// register byte addresses (wishbone, one word each)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_REF_SOURCE  = 4'h0;
	localparam logic [3:0] ADDR_LOOP_MODE   = 4'h4;
	localparam logic [3:0] ADDR_DECIMATION  = 4'h8;
	localparam logic [3:0] ADDR_CRYSTAL     = 4'hc;
	localparam logic [3:0] ADDR_LOOP_STATUS = 4'h0;
	localparam logic [3:0] ADDR_STATUS_HI   = 4'h1;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int POLICY_LSB   = 6;
	localparam int MANUAL_BIT   = 4;
	localparam int REVERT_BIT   = 1;
	localparam int SEAMLESS_BIT = 0;
	localparam int SWAP_BIT     = 7;
	localparam int LOST_BIT     = 6;
	localparam int FREEZE_BIT   = 3;
	localparam int ENABLE_BIT   = 2;
	localparam int STATE_LSB    = 0;
	localparam int SW_SHIFT_LSB = 4;
	localparam int MN_SHIFT_LSB = 0;

	// ------------------------------------------------------------
	// writable masks and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] REF_SOURCE_MASK  = 8'hd3;
	localparam logic [7:0] LOOP_MODE_MASK   = 8'hcf;
	localparam logic [7:0] DECIMATION_MASK  = 8'h7f;
	localparam logic [7:0] CRYSTAL_MASK     = 8'hff;
	localparam logic [7:0] REF_SOURCE_RESET = 8'h00;
	localparam logic [7:0] LOOP_MODE_RESET  = 8'h81;
	localparam logic [7:0] DECIMATION_RESET = 8'h36;
	localparam logic [7:0] CRYSTAL_RESET    = 8'h00;

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [1:0] POLICY_MANUAL = 2'h0;
	localparam logic [1:0] POLICY_AUTO   = 2'h2;
	localparam logic [1:0] SEL_FREERUN   = 2'h0;
	localparam logic [1:0] SEL_NORMAL    = 2'h1;
	localparam logic [1:0] SEL_HOLDOVER  = 2'h2;
	localparam logic [1:0] SEL_WRITEFREQ = 2'h3;

	typedef enum logic [2:0] {
		ST_FREERUN, ST_ACQUIRE, ST_LOCKED, ST_HOLDOVER, ST_WRITEFREQ, ST_SYNTH
	} loop_state_e;
endpackage : dpll_ctrl_pkg

// ==== tb/dpll_mode_control_regs_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// port checks
// ----
module dpll_mode_control_regs_monitor (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        freq_word_wr,
	input wire logic        hitless_en,
	input wire logic        use_lock_filter,
	input wire logic        filter_update_en,
	input wire logic        loop_clk_en,
	input wire logic [3:0]  main_decim_shift,
	input wire logic        main_decim_bypass,
	input wire logic [2:0]  switch_decim_shift,
	input wire logic [2:0]  loop_state
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// mode write with the loop enabled, then its ack
	sequence s_mode(logic [1:0] m);
		wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h4
			&& wb_dat_i[2] && wb_dat_i[1:0] == m ##1 wb_ack_o;
	endsequence
	sequence s_rd_ref;
		wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == 4'h0 ##1 wb_ack_o;
	endsequence
	property p_bypass; main_decim_bypass == (main_decim_shift == 4'h0); endproperty
	a_bypass: assert property (p_bypass) else $error("bypass mismatch");
	property p_switch; !hitless_en |-> switch_decim_shift == 3'h0; endproperty
	a_switch: assert property (p_switch) else $error("switch shift not ignored");
	property p_synth; !loop_clk_en [*3] |-> loop_state == 3'h5; endproperty
	a_synth: assert property (p_synth) else $error("disabled loop not synth");
	property p_lock; use_lock_filter |-> loop_state == 3'h1; endproperty
	a_lock: assert property (p_lock) else $error("lock filter outside acquire");
	property p_freeze; $rose(freq_word_wr) |-> ##[1:8] !filter_update_en; endproperty
	a_freeze: assert property (p_freeze) else $error("no filter suppress");
	property p_free; s_mode(2'h0) |-> ##[1:4] loop_state == 3'h0; endproperty
	a_free: assert property (p_free) else $error("not freerun");
	property p_hold; s_mode(2'h2) |-> ##[1:4] loop_state == 3'h3; endproperty
	a_hold: assert property (p_hold) else $error("not holdover");
	property p_wfreq; s_mode(2'h3) |-> ##[1:4] loop_state == 3'h4; endproperty
	a_wfreq: assert property (p_wfreq) else $error("not write frequency");
	property p_rsvd; s_rd_ref |-> (wb_dat_o[7:0] & 8'h2c) == 8'h00; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule : dpll_mode_control_regs_monitor
`default_nettype wire

// ==== tb/dpll_mode_control_regs_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module dpll_mode_control_regs_test;
	logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, errf;
	logic ref_a_valid, ref_b_valid, lock_achieved, freq_word_wr, ref_input_b_sel;
	logic revertive_en, hitless_en, use_lock_filter, filter_update_en, loop_clk_en;
	logic main_decim_bypass;
	logic [3:0] wb_adr_i, wb_sel_i, main_decim_shift;
	logic [31:0] wb_dat_i, wb_dat_o, rdat;
	logic [2:0] switch_decim_shift, loop_state;
	logic signed [7:0] crystal_offset_ppm;
	int bad_count, checks, cyc_n, i, lows;
	typedef struct {logic w; logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_s;
	row_s rows[10];
	dpll_mode_control_regs dpll_mode_control_regs_inst (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
		.ref_a_valid, .ref_b_valid, .lock_achieved, .freq_word_wr, .ref_input_b_sel,
		.revertive_en, .hitless_en, .use_lock_filter, .filter_update_en, .loop_clk_en,
		.main_decim_shift, .main_decim_bypass, .switch_decim_shift, .crystal_offset_ppm,
		.loop_state);
	task automatic summarize;
		$display("checks %0d bad %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", n, e, g);
			bad_count++;
		end
	endtask : chk
	// one classic cycle; waits on ack or err, the timeout below ends a hang
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] s);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= s;
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		rdat = wb_dat_o;
		errf = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		wb(1'b1, a, d, 4'hf);
	endtask : wr
	task automatic wait_state(input logic [2:0] e);
		for (int k = 0; k < 20 && loop_state !== e; k++) @(posedge clk);
		chk("loop_state", {29'h0, e}, {29'h0, loop_state});
	endtask : wait_state
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 5000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, lock_achieved, freq_word_wr} = 6'h00;
		{wb_adr_i, wb_sel_i, wb_dat_i, cyc_n} = '0;
		{ref_a_valid, ref_b_valid} = 2'h3;
		rows = '{'{1'b0, 4'h0, 8'h00, 8'h00}, '{1'b0, 4'h4, 8'h00, 8'h81},
			'{1'b0, 4'h8, 8'h00, 8'h36}, '{1'b0, 4'hc, 8'h00, 8'h00},
			'{1'b1, 4'h0, 8'hff, 8'hd3}, '{1'b1, 4'h4, 8'hff, 8'hcf},
			'{1'b1, 4'h8, 8'hff, 8'h7f}, '{1'b1, 4'hc, 8'h80, 8'h80},
			'{1'b1, 4'h0, 8'h00, 8'h00}, '{1'b1, 4'h8, 8'h36, 8'h36}};
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		chk("reset state", 32'h5, {29'h0, loop_state});
		for (i = 0; i < 10; i++) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			wb(1'b0, rows[i].a, 8'h00, 4'hf);
			chk("readback", {24'h0, rows[i].e}, {rdat[31:11], 3'h0, rdat[7:0]});
			if (rows[i].a == 4'h4)
				chk("state field", {29'h0, loop_state}, {29'h0, rdat[10:8]});
		end
		$display("table done");
		wr(4'h0, 8'h10);
		repeat (2) @(posedge clk);
		wait_state(3'h4);
		chk("manual b", 1, ref_input_b_sel);
		wr(4'h0, 8'h00);
		repeat (2) @(posedge clk);
		chk("manual a", 0, ref_input_b_sel);
		wr(4'h0, 8'h80);
		repeat (4) @(posedge clk);
		chk("auto a", 0, ref_input_b_sel);
		ref_a_valid <= 1'b0;
		repeat (10) @(posedge clk);
		chk("auto b", 1, ref_input_b_sel);
		ref_a_valid <= 1'b1;
		wr(4'h0, 8'h03);
		chk("revert", 1, revertive_en);
		chk("hitless", 1, hitless_en);
		chk("sw shift", 3, switch_decim_shift);
		wr(4'h8, 8'h30);
		chk("bypass", 1, main_decim_bypass);
		wr(4'h0, 8'h00);
		chk("sw off", 0, switch_decim_shift);
		chk("revert off", 0, revertive_en);
		wr(4'hc, 8'hf6);
		chk("trim", 32'hfffffff6, crystal_offset_ppm);
		wb(1'b1, 4'hc, 8'h55, 4'h0);
		wb(1'b0, 4'hc, 8'h00, 4'hf);
		chk("sel off", 32'hf6, rdat);
		wb(1'b0, 4'h2, 8'h00, 4'hf);
		chk("unmapped", 32'h0, rdat);
		chk("err", 32'h1, {31'h0, errf});
		$display("fields done");
		wr(4'h4, 8'h0c);
		chk("frozen", 0, filter_update_en);
		wait_state(3'h0);
		wr(4'h4, 8'h0e);
		wait_state(3'h3);
		wr(4'h4, 8'h0f);
		wait_state(3'h4);
		wr(4'h4, 8'h85);
		wait_state(3'h1);
		chk("lock filter", 1, use_lock_filter);
		wr(4'h4, 8'h05);
		chk("normal filter", 0, use_lock_filter);
		lock_achieved <= 1'b1;
		wait_state(3'h2);
		ref_a_valid <= 1'b0;
		wait_state(3'h3);
		ref_a_valid <= 1'b1;
		wait_state(3'h2);
		wr(4'h4, 8'h45);
		ref_a_valid <= 1'b0;
		wait_state(3'h0);
		ref_a_valid <= 1'b1;
		wr(4'h4, 8'h05);
		freq_word_wr <= 1'b1;
		lows = 0;
		repeat (12) begin
			@(posedge clk);
			lows += int'(filter_update_en === 1'b0);
		end
		chk("suppress", 1, lows);
		wr(4'h4, 8'h01);
		wait_state(3'h5);
		chk("clk gate", 0, loop_clk_en);
		$display("modes done");
		summarize();
	end
endmodule : dpll_mode_control_regs_test
bind dpll_mode_control_regs dpll_mode_control_regs_monitor dpll_mode_control_regs_monitor_inst (
	.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
	.wb_dat_o, .wb_ack_o, .freq_word_wr, .hitless_en, .use_lock_filter, .filter_update_en,
	.loop_clk_en, .main_decim_shift, .main_decim_bypass, .switch_decim_shift, .loop_state);
`default_nettype wire
